// ==== hw/vrs_sequencer.sv ====
/*
 * vrs_sequencer: enable/disable, start-up ramp, dynamic code stepping and
 * protection masking for a multiphase buck reference.
 * Assumes pins are asynchronous (synchronised here), control-loop driver
 * requests are on clock_in, and the register port is a plain strobe bus.
 */
// Implementation choices: the register offsets and the plain strobed port.
// Function
// (RULE1) mask protections during transition, plus 32 steps
// (RULE2) one step equals one reference lsb
// (RULE3) detect on rise, confirm on fall
// (RULE4) step one lsb per stepping cycle
// (RULE5) ignore code changes during transition
// (RULE6) stepping clock 1 MHz or 250 kHz
// (RULE7) six-bit transition indicator covers settle delay
// (RULE8) processor paces code changes itself
// (RULE9) supplies bad keeps all drivers off
// (RULE10) enable released starts ramp to code
// (RULE11) enable low clears faults, drivers off
// (RULE12) ramp only with supplies and enable
// (RULE13) power-good released when ramp reaches code
// (RULE14) undervoltage from 0.6 V, overvoltage always
// (RULE15) eight-bit: delay, boot ramp, hold, ramp
// (RULE16) eight-bit ramp on start-up oscillator
// (RULE17) eight-bit fixed overvoltage threshold before boot
// (RULE18) code below boot steps down from boot
// (RULE19) six-bit ramp on main oscillator
// (RULE20) six-bit start-up fixed or external threshold
// (RULE21) low side held until high side switches
// (RULE22) overvoltage still forces low side on
// (RULE23) undervoltage over one period latches off
// (RULE24) overvoltage latches low on, high off
// (RULE25) code lines pass two-flop synchroniser
// (RULE26) reference stops exactly at target
`timescale 1ns/1ps
module vrs_sequencer #(
	parameter int unsigned PHASES    = 3,
	parameter int unsigned RATE_W    = 12,
	parameter int unsigned T1_CYCLES = vrs_pkg::T1_CYCLES,
	parameter int unsigned T3_CYCLES = vrs_pkg::T3_CYCLES
) (
	input  wire logic              clock_in,
	input  wire logic              arst_n_in,
	input  wire logic [3:0]        reg_addr_in,
	input  wire logic [31:0]       reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output logic [31:0]            reg_rdata_out,
	input  wire logic [7:0]        code_in,
	input  wire logic              logic_supply_good_in,
	input  wire logic              driver_supply_good_in,
	input  wire logic              output_enable_pin_in,
	input  wire logic              main_oscillator_pin_in,
	input  wire logic [RATE_W-1:0] startup_rate_select_pin_in,
	input  wire logic              undervoltage_compare_in,
	input  wire logic              overvoltage_compare_in,
	input  wire logic [PHASES-1:0] high_side_switching_in,
	input  wire logic [PHASES-1:0] loop_high_side_req_in,
	input  wire logic [PHASES-1:0] loop_low_side_req_in,
	input  wire logic              start_done_power_good_in,
	output logic                   start_done_power_good_out,
	output logic                   start_done_power_good_oe_n_out,
	output logic [7:0]             reference_code_out,
	output logic                   transition_indicator_out,
	output logic                   undervoltage_detection_out,
	output logic                   overvoltage_detection_out,
	output logic [1:0]             ov_threshold_sel_out,
	output logic                   fault_out,
	output logic [PHASES-1:0]      high_side_driver_out,
	output logic [PHASES-1:0]      low_side_driver_out
);
	localparam int unsigned MISC_W = vrs_pkg::PIN_HS_BASE + PHASES;
	localparam int unsigned TW     = vrs_pkg::TIMER_W;

	typedef struct packed {
		logic [MISC_W-1:0]      misc_s1;
		logic [MISC_W-1:0]      misc_s2;
		logic [7:0]             code_s1;
		logic [7:0]             code_s2;
		logic [RATE_W-1:0]      rate_s1;
		logic [RATE_W-1:0]      rate_s2;
		logic                   osc_prev;
		logic [1:0]             ctrl;
		logic [31:0]            rdata;
		vrs_pkg::vrs_seq_e      state;
		vrs_pkg::vrs_transition_indicator_e     dv;
		logic [7:0]             refc;
		logic [7:0]             target;
		logic [7:0]             cand;
		logic [TW-1:0]          timer;
		logic [5:0]             settle;
		logic                   uv_seen;
		logic                   uv_fault;
		logic                   ov_fault;
		logic                   boot_done;
		logic [PHASES-1:0]      hs_started;
		logic [PHASES-1:0]      hs_drv;
		logic [PHASES-1:0]      ls_drv;
		logic                   pg_release;
		logic                   trans_ind;
		logic                   uv_en;
		logic                   ov_en;
		vrs_pkg::vrs_ovsel_e    ov_sel;
	} vrs_state_s;

	vrs_state_s r;
	vrs_state_s next_r;
	logic       step_rise, step_fall, ss_tick, six_bit;

	assign six_bit = r.ctrl[vrs_pkg::CTRL_SIX_BIT];

	vrs_tick_div #(
		.W (9)
	) u_step_div (
		.clock_in   (clock_in),
		.arst_n_in  (arst_n_in),
		.enable_in  (r.state == vrs_pkg::ST_RUN),
		.divisor_in (six_bit ? vrs_pkg::STEP_DIV_SIX : vrs_pkg::STEP_DIV_EIGHT), // RULE6
		.tick_out   (step_rise),
		.half_out   (step_fall)
	);

	// start-up oscillator rate follows the select pin, period in clocks
	vrs_tick_div #(
		.W (RATE_W)
	) u_ss_div (
		.clock_in   (clock_in),
		.arst_n_in  (arst_n_in),
		.enable_in  (r.state == vrs_pkg::ST_RAMP_BOOT || r.state == vrs_pkg::ST_RAMP_FINAL),
		.divisor_in (r.rate_s2), // RULE16
		.tick_out   (ss_tick),
		.half_out   ()
	);

	always_comb begin
		logic              supplies_ok, enabled, main_tick, ramp_tick, uv_cmp;
		logic              ov_cmp, ov_ext, masked, active;
		logic [7:0]        code_m, stepped;
		logic [PHASES-1:0] hs_sw;
		supplies_ok = r.misc_s2[vrs_pkg::PIN_LOGIC_GOOD] & r.misc_s2[vrs_pkg::PIN_DRIVER_GOOD];
		enabled     = supplies_ok & r.misc_s2[vrs_pkg::PIN_OUT_ENABLE];
		masked = (r.state == vrs_pkg::ST_RUN)
			&& (r.dv == vrs_pkg::DV_STEP || r.dv == vrs_pkg::DV_SETTLE); // RULE1
		active = enabled && (r.state == vrs_pkg::ST_RAMP_BOOT || r.state == vrs_pkg::ST_HOLD
			|| r.state == vrs_pkg::ST_RAMP_FINAL || r.state == vrs_pkg::ST_RUN);
		main_tick   = r.misc_s2[vrs_pkg::PIN_MAIN_OSC] & ~r.osc_prev;
		uv_cmp      = r.misc_s2[vrs_pkg::PIN_UV_CMP];
		ov_cmp      = r.misc_s2[vrs_pkg::PIN_OV_CMP];
		hs_sw       = r.misc_s2[vrs_pkg::PIN_HS_BASE +: PHASES];
		ov_ext      = r.ctrl[vrs_pkg::CTRL_OVP_EXT];
		code_m      = six_bit ? {2'h0, r.code_s2[5:0] & vrs_pkg::CODE6_MASK} : r.code_s2;
		ramp_tick   = six_bit ? main_tick : ss_tick; // RULE16 RULE19
		// one lsb toward target, never past it
		if (r.refc < r.target) begin
			stepped = r.refc + 8'h01; // RULE2 RULE26
		end else if (r.refc > r.target) begin
			stepped = r.refc - 8'h01; // RULE26
		end else begin
			stepped = r.refc;
		end

		next_r          = r;
		next_r.misc_s1  = {high_side_switching_in, start_done_power_good_in,
			overvoltage_compare_in, undervoltage_compare_in, main_oscillator_pin_in,
			output_enable_pin_in, driver_supply_good_in, logic_supply_good_in};
		next_r.misc_s2  = r.misc_s1;
		next_r.code_s1  = code_in;
		next_r.code_s2  = r.code_s1; // RULE25
		next_r.rate_s1  = startup_rate_select_pin_in;
		next_r.rate_s2  = r.rate_s1;
		next_r.osc_prev = r.misc_s2[vrs_pkg::PIN_MAIN_OSC];

		if (reg_wr_in && reg_addr_in == vrs_pkg::REG_CTRL) begin
			next_r.ctrl = reg_wdata_in[1:0];
		end

		if (!enabled) begin
			// supply loss or enable low resets every latch
			next_r.state      = vrs_pkg::ST_OFF; // RULE9 RULE11
			next_r.dv         = vrs_pkg::DV_IDLE;
			next_r.refc       = 8'h00; // RULE12
			next_r.target     = 8'h00;
			next_r.timer      = '0;
			next_r.uv_fault   = 1'b0; // RULE11
			next_r.ov_fault   = 1'b0; // RULE11
			next_r.uv_seen    = 1'b0;
			next_r.boot_done  = 1'b0;
			next_r.hs_started = '0;
		end else begin
			unique case (r.state)
			vrs_pkg::ST_OFF: begin
				next_r.timer = '0;
				if (six_bit) begin
					next_r.target = code_m; // RULE19
					next_r.state  = vrs_pkg::ST_RAMP_FINAL; // RULE10 RULE12
				end else begin
					next_r.state = vrs_pkg::ST_DELAY; // RULE10 RULE12
				end
			end
			vrs_pkg::ST_DELAY: begin
				next_r.timer = r.timer + 1'b1;
				if (r.timer == TW'(T1_CYCLES - 1)) begin
					next_r.state  = vrs_pkg::ST_RAMP_BOOT; // RULE15
					next_r.target = vrs_pkg::BOOT_CODE;
				end
			end
			vrs_pkg::ST_RAMP_BOOT: begin
				if (r.refc == vrs_pkg::BOOT_CODE) begin
					next_r.boot_done = 1'b1; // RULE17
					next_r.timer     = '0;
					next_r.state     = vrs_pkg::ST_HOLD; // RULE15
				end else if (ss_tick) begin
					next_r.refc = stepped; // RULE15
				end
			end
			vrs_pkg::ST_HOLD: begin
				next_r.timer = r.timer + 1'b1;
				if (r.timer == TW'(T3_CYCLES - 1)) begin
					next_r.target = code_m; // RULE15 RULE18
					next_r.state  = vrs_pkg::ST_RAMP_FINAL;
				end
			end
			vrs_pkg::ST_RAMP_FINAL: begin
				if (r.refc == r.target) begin
					next_r.state = vrs_pkg::ST_RUN; // RULE13
				end else if (ramp_tick) begin
					next_r.refc = stepped; // RULE18 RULE19
				end
			end
			vrs_pkg::ST_RUN: begin
				unique case (r.dv)
				vrs_pkg::DV_IDLE: begin
					if (step_rise && code_m != r.refc) begin
						next_r.cand = code_m; // RULE3
						next_r.dv   = vrs_pkg::DV_CONFIRM;
					end
				end
				vrs_pkg::DV_CONFIRM: begin
					if (step_fall) begin
						if (code_m == r.cand) begin
							next_r.target = r.cand; // RULE3
							next_r.dv     = vrs_pkg::DV_STEP;
						end else begin
							next_r.dv = vrs_pkg::DV_IDLE;
						end
					end
				end
				vrs_pkg::DV_STEP: begin
					// code lines not looked at until settle ends
					if (step_rise) begin
						next_r.refc = stepped; // RULE4 RULE5 RULE8
						if (stepped == r.target) begin
							next_r.settle = 6'h00;
							next_r.dv     = vrs_pkg::DV_SETTLE;
						end
					end
				end
				vrs_pkg::DV_SETTLE: begin
					if (step_rise) begin
						next_r.settle = r.settle + 6'h01;
						if (r.settle == vrs_pkg::SETTLE_STEPS - 6'h01) begin
							next_r.dv = vrs_pkg::DV_IDLE; // RULE1 RULE5
						end
					end
				end
				endcase
			end
			vrs_pkg::ST_FAULT: begin
				next_r.state = vrs_pkg::ST_FAULT;
			end
			default: begin
				next_r.state = vrs_pkg::ST_OFF;
			end
			endcase

			// undervoltage must persist across a full main oscillator period
			if (!uv_cmp) begin
				next_r.uv_seen = 1'b0;
			end else if (main_tick) begin
				next_r.uv_seen = 1'b1;
				if (r.uv_seen && r.uv_en) begin
					next_r.uv_fault = 1'b1; // RULE23
					next_r.state    = vrs_pkg::ST_FAULT;
				end
			end
			if (ov_cmp && r.ov_en) begin
				next_r.ov_fault = 1'b1; // RULE24
				next_r.state    = vrs_pkg::ST_FAULT;
			end
		end

		next_r.ov_en = enabled && r.state != vrs_pkg::ST_OFF
			&& r.state != vrs_pkg::ST_FAULT && !masked; // RULE1 RULE14
		next_r.uv_en = active && !masked
			&& r.refc >= (six_bit ? vrs_pkg::UV_CODE_SIX : vrs_pkg::UV_CODE_EIGHT); // RULE14
		if (six_bit) begin
			next_r.ov_sel = ov_ext ? vrs_pkg::OV_EXTERNAL : vrs_pkg::OV_FIXED_HIGH; // RULE20
		end else if (!r.boot_done) begin
			next_r.ov_sel = vrs_pkg::OV_FIXED_LOW; // RULE17
		end else begin
			next_r.ov_sel = ov_ext ? vrs_pkg::OV_EXTERNAL : vrs_pkg::OV_FROM_CODE; // RULE17
		end

		next_r.hs_started = enabled ? (r.hs_started | (hs_sw & {PHASES{active}})) : '0;
		next_r.hs_drv     = active ? loop_high_side_req_in : '0; // RULE9 RULE11
		if (next_r.ov_fault) begin
			// same edge as the latch: fault never shows with lows off
			next_r.hs_drv = '0; // RULE24
			next_r.ls_drv = '1; // RULE22 RULE24
		end else if (active) begin
			next_r.ls_drv = loop_low_side_req_in & r.hs_started; // RULE21
		end else begin
			next_r.ls_drv = '0; // RULE9 RULE11 RULE23
		end

		next_r.pg_release = enabled && r.state == vrs_pkg::ST_RUN
			&& !(six_bit && masked); // RULE1 RULE11 RULE13
		next_r.trans_ind  = six_bit && masked; // RULE7

		next_r.rdata = 32'h0000_0000;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
			vrs_pkg::REG_CTRL: begin
				next_r.rdata[1:0] = r.ctrl;
			end
			vrs_pkg::REG_STATUS: begin
				next_r.rdata[vrs_pkg::STAT_STATE +: 3] = r.state;
				next_r.rdata[vrs_pkg::STAT_TRANSITION_INDICATOR +: 2]  = r.dv;
				next_r.rdata[vrs_pkg::STAT_UV]         = r.uv_fault;
				next_r.rdata[vrs_pkg::STAT_OV]         = r.ov_fault;
				next_r.rdata[vrs_pkg::STAT_TRANS]      = masked;
				next_r.rdata[vrs_pkg::STAT_PG_PIN]     = r.misc_s2[vrs_pkg::PIN_PG_LEVEL];
				next_r.rdata[vrs_pkg::STAT_PG_REL]     = r.pg_release;
				next_r.rdata[vrs_pkg::STAT_BOOT]       = r.boot_done;
			end
			vrs_pkg::REG_REF: begin
				next_r.rdata[7:0]                      = r.refc;
				next_r.rdata[vrs_pkg::REF_TARGET +: 8] = r.target;
			end
			default: begin
				next_r.rdata = 32'h0000_0000;
			end
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			r        <= '0;
			r.ctrl   <= vrs_pkg::CTRL_RESET;
			r.state  <= vrs_pkg::ST_OFF;
			r.dv     <= vrs_pkg::DV_IDLE;
			r.ov_sel <= vrs_pkg::OV_FIXED_LOW;
		end else begin
			r <= next_r;
		end
	end

	assign reg_rdata_out                  = r.rdata;
	assign start_done_power_good_out      = 1'b0;
	assign start_done_power_good_oe_n_out = r.pg_release;
	assign reference_code_out             = r.refc;
	assign transition_indicator_out       = r.trans_ind;
	assign undervoltage_detection_out     = r.uv_en;
	assign overvoltage_detection_out      = r.ov_en;
	assign ov_threshold_sel_out           = r.ov_sel;
	assign fault_out                      = r.ov_fault;
	assign high_side_driver_out           = r.hs_drv;
	assign low_side_driver_out            = r.ls_drv;
endmodule

// ==== hw/vrs_pkg.sv ====
/*
 * vrs_pkg: constants, register map and state types of the reference
 * sequencer. Assumes a single 125 MHz system clock.
 */
package vrs_pkg;

	localparam int unsigned CLK_HZ        = 125_000_000;
	// stepping clock rates per code mode
	localparam int unsigned STEP_HZ_EIGHT = 1_000_000;
	localparam int unsigned STEP_HZ_SIX   = 250_000;
	localparam logic [8:0]  STEP_DIV_EIGHT = 9'(CLK_HZ / STEP_HZ_EIGHT);
	localparam logic [8:0]  STEP_DIV_SIX   = 9'(CLK_HZ / STEP_HZ_SIX);

	// start-up delays, least times round up
	localparam int unsigned T1_US       = 1000;
	localparam int unsigned T3_US       = 75;
	localparam int unsigned T1_CYCLES   = (T1_US * (CLK_HZ / 1_000_000));
	localparam int unsigned T3_CYCLES   = (T3_US * (CLK_HZ / 1_000_000));
	localparam int unsigned TIMER_W     = 17;
	localparam logic [5:0]  SETTLE_STEPS = 6'h20;

	// reference lsb in microvolts
	localparam int unsigned LSB_UV_EIGHT = 6250;
	localparam int unsigned LSB_UV_SIX   = 25000;
	localparam int unsigned BOOT_UV      = 1_081_000;
	localparam int unsigned UV_EN_UV     = 600_000;
	localparam logic [7:0]  BOOT_CODE    = 8'(BOOT_UV / LSB_UV_EIGHT);
	localparam logic [7:0]  UV_CODE_EIGHT = 8'(UV_EN_UV / LSB_UV_EIGHT);
	localparam logic [7:0]  UV_CODE_SIX   = 8'(UV_EN_UV / LSB_UV_SIX);
	localparam logic [5:0]  CODE6_MASK    = 6'h3F;

	// synchronised pin vector layout
	localparam int unsigned PIN_LOGIC_GOOD  = 0;
	localparam int unsigned PIN_DRIVER_GOOD = 1;
	localparam int unsigned PIN_OUT_ENABLE  = 2;
	localparam int unsigned PIN_MAIN_OSC    = 3;
	localparam int unsigned PIN_UV_CMP      = 4;
	localparam int unsigned PIN_OV_CMP      = 5;
	localparam int unsigned PIN_PG_LEVEL    = 6;
	localparam int unsigned PIN_HS_BASE     = 7;

	// register bus
	localparam int unsigned ADDR_W     = 4;
	localparam logic [3:0]  REG_CTRL   = 4'h0;
	localparam logic [3:0]  REG_STATUS = 4'h4;
	localparam logic [3:0]  REG_REF    = 4'h8;
	localparam int unsigned CTRL_SIX_BIT = 0;
	localparam int unsigned CTRL_OVP_EXT = 1;
	localparam logic [1:0]  CTRL_RESET   = 2'h0;
	localparam int unsigned STAT_STATE   = 0;
	localparam int unsigned STAT_TRANSITION_INDICATOR    = 4;
	localparam int unsigned STAT_UV      = 8;
	localparam int unsigned STAT_OV      = 9;
	localparam int unsigned STAT_TRANS   = 10;
	localparam int unsigned STAT_PG_PIN  = 11;
	localparam int unsigned STAT_PG_REL  = 12;
	localparam int unsigned STAT_BOOT    = 13;
	localparam int unsigned REF_TARGET   = 8;

	typedef enum logic [2:0] {
		ST_OFF, ST_DELAY, ST_RAMP_BOOT, ST_HOLD, ST_RAMP_FINAL, ST_RUN, ST_FAULT
	} vrs_seq_e;

	typedef enum logic [1:0] {DV_IDLE, DV_CONFIRM, DV_STEP, DV_SETTLE} vrs_transition_indicator_e;

	// overvoltage threshold source: fixed low (1.24 V), code, external, fixed high (1.8 V)
	typedef enum logic [1:0] {OV_FIXED_LOW, OV_FROM_CODE, OV_EXTERNAL, OV_FIXED_HIGH} vrs_ovsel_e;

endpackage

// ==== hw/vrs_tick_div.sv ====
/*
 * vrs_tick_div: programmable divider giving one-cycle tick and half-period
 * pulses. Assumes divisor is static while enabled; zero acts as one.
 */
`timescale 1ns/1ps
module vrs_tick_div #(
	parameter int unsigned W = 9
) (
	input  wire logic         clock_in,
	input  wire logic         arst_n_in,
	input  wire logic         enable_in,
	input  wire logic [W-1:0] divisor_in,
	output logic              tick_out,
	output logic              half_out
);
	typedef struct packed {
		logic [W-1:0] count;
		logic         tick;
		logic         half;
	} vrs_div_s;

	vrs_div_s r;
	vrs_div_s next_r;

	always_comb begin
		next_r      = r;
		next_r.tick = 1'b0;
		next_r.half = 1'b0;
		if (!enable_in) begin
			next_r.count = '0;
		end else if ({1'b0, r.count} + 1'b1 >= {1'b0, divisor_in}) begin
			next_r.count = '0;
			next_r.tick  = 1'b1;
		end else begin
			next_r.count = r.count + 1'b1;
			next_r.half  = (r.count == (divisor_in >> 1));
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign tick_out = r.tick;
	assign half_out = r.half;
endmodule

// ==== testbench/vrs_seq_props.sv ====
/*
 * vrs_seq_props: port-level checker for vrs_sequencer, bound to it.
 * Assumes one clock_in domain and asynchronous active-low arst_n_in.
 */
`timescale 1ns/1ps
module vrs_seq_props #(
	parameter int unsigned PHASES = 3,
	parameter int unsigned RATE_W = 12
) (
	input wire logic		clock_in,
	input wire logic		arst_n_in,
	input wire logic [3:0]		reg_addr_in,
	input wire logic [31:0]		reg_wdata_in,
	input wire logic		reg_wr_in,
	input wire logic		reg_rd_in,
	input wire logic [31:0]		reg_rdata_out,
	input wire logic [7:0]		code_in,
	input wire logic		logic_supply_good_in,
	input wire logic		driver_supply_good_in,
	input wire logic		output_enable_pin_in,
	input wire logic		main_oscillator_pin_in,
	input wire logic [RATE_W-1:0]	startup_rate_select_pin_in,
	input wire logic		undervoltage_compare_in,
	input wire logic		overvoltage_compare_in,
	input wire logic [PHASES-1:0]	high_side_switching_in,
	input wire logic [PHASES-1:0]	loop_high_side_req_in,
	input wire logic [PHASES-1:0]	loop_low_side_req_in,
	input wire logic		start_done_power_good_in,
	input wire logic		start_done_power_good_out,
	input wire logic		start_done_power_good_oe_n_out,
	input wire logic [7:0]		reference_code_out,
	input wire logic		transition_indicator_out,
	input wire logic		undervoltage_detection_out,
	input wire logic		overvoltage_detection_out,
	input wire logic [1:0]		ov_threshold_sel_out,
	input wire logic		fault_out,
	input wire logic [PHASES-1:0]	high_side_driver_out,
	input wire logic [PHASES-1:0]	low_side_driver_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);

	a_fault_drivers: assert property (fault_out |->
		low_side_driver_out == {PHASES{1'b1}} && high_side_driver_out == '0)
		else $error("fault without safe drivers");
	a_ov_latch: assert property (
		(overvoltage_compare_in && overvoltage_detection_out)[*3] |-> ##[0:3] fault_out)
		else $error("overvoltage not latched");
	a_supply_off: assert property (
		(!logic_supply_good_in || !driver_supply_good_in)[*5] |->
		high_side_driver_out == '0 && low_side_driver_out == '0)
		else $error("drivers on with bad supply");
	a_enable_low: assert property ((!output_enable_pin_in)[*5] |->
		!start_done_power_good_oe_n_out && !fault_out && low_side_driver_out == '0
		&& high_side_driver_out == '0) else $error("enable low not honoured");
	a_ref_idle: assert property (
		(!logic_supply_good_in || !driver_supply_good_in || !output_enable_pin_in)[*5]
		|-> reference_code_out == 8'h00) else $error("reference moved while off");
	a_pg_ref: assert property ($rose(start_done_power_good_oe_n_out) |->
		reference_code_out == code_in || reference_code_out == {2'h0, code_in[5:0]})
		else $error("power good before target");
	a_ref_step: assert property ($changed(reference_code_out) |->
		reference_code_out == $past(reference_code_out) + 8'h01 ||
		reference_code_out == $past(reference_code_out) - 8'h01 ||
		reference_code_out == 8'h00) else $error("reference jumped");
	a_mask_trans: assert property (transition_indicator_out |->
		!overvoltage_detection_out && !undervoltage_detection_out)
		else $error("protection live in transition");
	a_ls_held: assert property ((!high_side_switching_in[0] && !fault_out)[*4]
		|-> !low_side_driver_out[0]) else $error("low side before high side");
	a_uv_ref: assert property ($rose(undervoltage_detection_out) |->
		reference_code_out >= vrs_pkg::UV_CODE_SIX) else $error("uv enabled too low");

	c_fault: cover property ($rose(fault_out));
	c_trans: cover property ($fell(transition_indicator_out));
	c_pg: cover property ($rose(start_done_power_good_oe_n_out));
endmodule

bind vrs_sequencer vrs_seq_props #(.PHASES(PHASES), .RATE_W(RATE_W)) props (.*);

// ==== testbench/vrs_cpu_model.sv ====
/*
 * vrs_cpu_model: processor side driving the voltage code lines.
 * Assumes the bench sets the target; pace zero means immediate change.
 */
`timescale 1ns/1ps
module vrs_cpu_model (
	input wire logic		clock_in,
	input wire logic [7:0]		target_in,
	input wire logic [15:0]		pace_in,
	output logic [7:0]		code_out
);
	logic [7:0]	code_q = 8'h00;
	logic [15:0]	wait_cnt = 16'h0000;

	assign code_out = code_q;

	// pacing one lsb at a time keeps the output slope under control
	always @(posedge clock_in) begin
		if (code_q == target_in) begin
			wait_cnt <= 16'h0000;
		end else if (pace_in == 16'h0000) begin
			code_q <= target_in;
		end else if (wait_cnt < pace_in) begin
			wait_cnt <= wait_cnt + 16'h0001;
		end else begin
			wait_cnt <= 16'h0000;
			code_q <= (code_q < target_in) ? code_q + 8'h01 : code_q - 8'h01;
		end
	end
endmodule

// ==== testbench/testbench.sv ====
/*
 * testbench: self-checking bench for vrs_sequencer with a code-line model.
 * Assumes short start-up delays (20 and 10 clocks) set by parameter.
 */
`timescale 1ns/1ps
module testbench;
	typedef struct packed {logic six; logic [7:0] code; logic [1:0] sel;} vrs_row_s;

	logic		clock_in = 1'b0;
	logic		arst_n_in = 1'b0;
	logic [3:0]	reg_addr_in = 4'h0;
	logic [31:0]	reg_wdata_in = 32'h0;
	logic		reg_wr_in = 1'b0;
	logic		reg_rd_in = 1'b0;
	logic [31:0]	reg_rdata_out;
	logic [7:0]	code_in;
	logic		logic_supply_good_in = 1'b1;
	logic		driver_supply_good_in = 1'b0;
	logic		output_enable_pin_in = 1'b1;
	logic		main_oscillator_pin_in = 1'b0;
	logic [11:0]	startup_rate_select_pin_in = 12'h002;
	logic		undervoltage_compare_in = 1'b0;
	logic		overvoltage_compare_in = 1'b0;
	logic [2:0]	high_side_switching_in = 3'h0;
	logic [2:0]	loop_high_side_req_in = 3'h7;
	logic [2:0]	loop_low_side_req_in = 3'h7;
	wire logic	start_done_power_good_in;
	logic		start_done_power_good_out;
	logic		start_done_power_good_oe_n_out;
	logic [7:0]	reference_code_out;
	logic		transition_indicator_out;
	logic		undervoltage_detection_out;
	logic		overvoltage_detection_out;
	logic [1:0]	ov_threshold_sel_out;
	logic		fault_out;
	logic [2:0]	high_side_driver_out;
	logic [2:0]	low_side_driver_out;
	logic [7:0]	tgt = 8'h00;
	logic [15:0]	pace = 16'h0000;
	logic [31:0]	d;
	int		n_mismatch = 0;
	int		cmp_count = 0;
	int		cyc = 0;
	int		i;
	int		n;
	int		t0;
	vrs_row_s	rows [3] = '{'{1'b0, 8'hB0, 2'h1}, '{1'b0, 8'hA0, 2'h1}, '{1'b1, 8'h20, 2'h3}};

	// open drain with pull-up
	assign start_done_power_good_in = start_done_power_good_oe_n_out ? 1'b1
		: start_done_power_good_out;

	vrs_sequencer #(.T1_CYCLES(20), .T3_CYCLES(10)) dut (.*);
	vrs_cpu_model cpu (.clock_in(clock_in), .target_in(tgt), .pace_in(pace), .code_out(code_in));

	always #4 clock_in = ~clock_in;

	// main oscillator at one eighth of the clock
	always @(posedge clock_in) begin
		main_oscillator_pin_in <= cyc[2];
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			test_done;
		end
	end

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
		@(posedge clock_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= v;
		@(posedge clock_in);
		reg_wr_in <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
		@(posedge clock_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clock_in);
		reg_rd_in <= 1'b0;
		@(posedge clock_in);
		v = reg_rdata_out;
	endtask

	task automatic test_done;
		$display("mismatches %0d, compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge clock_in);
		arst_n_in <= 1'b1;
		@(posedge clock_in);
		chk_bit(start_done_power_good_oe_n_out, 1'b0);
		reg_read(4'h0, d);
		chk_val(d, 32'h0);
		reg_read(4'hC, d);
		chk_val(d, 32'h0);
		reg_write(4'h0, 32'h3);
		reg_read(4'h0, d);
		chk_val(d, 32'h3);
		reg_write(4'h8, 32'hFF);
		reg_read(4'h8, d);
		chk_val(d, 32'h0);
		chk_val(low_side_driver_out | high_side_driver_out, 32'h0);
		$display("reset and supply test done");
		driver_supply_good_in <= 1'b1;
		for (i = 0; i < 3; i++) begin
			output_enable_pin_in <= 1'b0;
			repeat (10) @(posedge clock_in);
			high_side_switching_in <= 3'h0;
			tgt <= rows[i].code;
			reg_write(4'h0, {31'h0, rows[i].six});
			repeat (10) @(posedge clock_in);
			output_enable_pin_in <= 1'b1;
			repeat (40) @(posedge clock_in);
			chk_val(low_side_driver_out, 32'h0);
			high_side_switching_in <= 3'h7;
			for (n = 0; n < 3000 && start_done_power_good_oe_n_out !== 1'b1; n++)
				@(posedge clock_in);
			chk_bit(start_done_power_good_oe_n_out, 1'b1);
			chk_bit(start_done_power_good_in, 1'b1);
			chk_val(reference_code_out, rows[i].code);
			chk_val(ov_threshold_sel_out, rows[i].sel);
			chk_bit(undervoltage_detection_out, 1'b1);
			$display("start-up row %0d done", i);
		end
		tgt <= 8'h22;
		for (n = 0; n < 3000 && reference_code_out !== 8'h21; n++) @(posedge clock_in);
		chk_bit(transition_indicator_out, 1'b1);
		chk_bit(overvoltage_detection_out, 1'b0);
		for (n = 0; n < 1000 && reference_code_out !== 8'h22; n++) @(posedge clock_in);
		chk_val(n, 32'd500);
		t0 = cyc;
		// slow change arriving during settle must be ignored
		pace <= 16'h0064;
		tgt <= 8'h25;
		repeat (1000) @(posedge clock_in);
		chk_val(reference_code_out, 8'h22);
		tgt <= 8'h22;
		for (n = 0; n < 20000 && transition_indicator_out !== 1'b0; n++) @(posedge clock_in);
		chk_bit(cyc - t0 >= 16000 && cyc - t0 <= 16003, 1'b1);
		repeat (2) @(posedge clock_in);
		chk_bit(overvoltage_detection_out, 1'b1);
		chk_bit(start_done_power_good_oe_n_out, 1'b1);
		$display("code change test done");
		overvoltage_compare_in <= 1'b1;
		repeat (8) @(posedge clock_in);
		chk_bit(fault_out, 1'b1);
		chk_val(low_side_driver_out, 32'h7);
		chk_val(high_side_driver_out, 32'h0);
		overvoltage_compare_in <= 1'b0;
		repeat (8) @(posedge clock_in);
		chk_bit(fault_out, 1'b1);
		output_enable_pin_in <= 1'b0;
		repeat (8) @(posedge clock_in);
		chk_bit(fault_out, 1'b0);
		chk_bit(start_done_power_good_oe_n_out, 1'b0);
		chk_bit(start_done_power_good_in, 1'b0);
		chk_val(low_side_driver_out, 32'h0);
		$display("fault test done");
		output_enable_pin_in <= 1'b1;
		for (n = 0; n < 3000 && start_done_power_good_oe_n_out !== 1'b1; n++)
			@(posedge clock_in);
		chk_bit(start_done_power_good_oe_n_out, 1'b1);
		chk_val(low_side_driver_out, 32'h7);
		undervoltage_compare_in <= 1'b1;
		repeat (30) @(posedge clock_in);
		undervoltage_compare_in <= 1'b0;
		repeat (8) @(posedge clock_in);
		chk_val(low_side_driver_out | high_side_driver_out, 32'h0);
		$display("undervoltage test done");
		test_done;
	end
endmodule
